// [hdl/csc_core_state.sv]
// core condition flags, product high byte, speed register and clock select
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/100ps
// Notes on behaviour
// - zero flag follows whether an affected result is zero.
// - digit carry is carry out of bit 3, inverted borrow on subtract.
// - carry is carry out of bit 7, inverted borrow on subtract.
// - rotate right loads carry with lsb, rotate left with msb.
// - three page bits extend 13-bit jump targets; page instruction sets them.
// - plain return skips if skip-after-return set, then clears it.
// - shadow skip flag records interrupt taken right after a skip.
// - product high byte to its register, low byte to working register.
// - speed register ignores writes; only speed, interrupt, interrupt return change it.
// - pll bit 0 enables multiplier, 1 disables it.
// - oscillator bit 1 stops oscillator and blocks external clock.
// - source field picks pll, oscillator, slow timer clock or off.
// - divisor field divides system clock by table; code 1111 stops it.
// - flash fetches at most one per three system clocks, ram one per clock; code grants one per two at divisor 1 or 2 if system clocks skip cycles.
// - one software vector; peripherals and eight external inputs interrupt.
// - core reset by pin, power-on, brown-out, watchdog or debug port.
// - taking an interrupt copies interrupt speed setting into speed register.
module csc_core_state
	import csc_pkg::*;
(
	input  wire logic                       clk,        // 40 MHz clock
	input  wire logic                       arst_n,     // async reset
	input  wire csc_instr_type              instr,      // retired instruction
	input  wire logic [2:0]                 reg_addr,   // register index
	input  wire logic [7:0]                 reg_wdata,  // write data
	input  wire logic                       reg_wr,     // write strobe
	input  wire logic                       reg_rd,     // read strobe
	output logic      [7:0]                 reg_rdata,  // read data
	input  wire logic                       pll_tick,   // pll clock strobe
	input  wire logic                       osc_tick,   // oscillator strobe
	input  wire logic                       rtc_tick,   // slow clock strobe
	input  wire logic                       fetch_req,  // core wants a fetch
	input  wire logic                       fetch_ram,  // fetch is from ram
	input  wire logic [CSC_NUM_EXT_IRQ-1:0] irq_ext,    // external requests
	input  wire logic                       irq_periph, // peripheral request
	input  wire logic [CSC_NUM_RST_SRC-1:0] rst_src,    // reset sources
	output logic      [7:0]                 status_r,   // condition flags
	output logic      [7:0]                 prodh_r,    // product high byte
	output logic      [7:0]                 work_r,     // working register
	output logic      [7:0]                 speed_r,    // speed register
	output logic                            skip_r,     // skipping state
	output logic                            pll_en_r,   // multiplier on
	output logic                            osc_en_r,   // oscillator on
	output logic                            core_tick_r,// core clock enable
	output logic                            fetch_ok_r, // fetch granted
	output logic                            irq_r,      // interrupt request
	output logic      [15:0]                vector_r,   // interrupt vector
	output logic                            core_rst_r  // core reset
);

	logic [7:0] ispeed_r;
	logic [7:0] saved_speed_r;
	logic [8:0] sum;
	logic [4:0] sum_lo;
	logic [15:0] prod;
	logic [7:0] res;
	logic       sys_tick;
	logic [7:0] div_cnt_r;
	logic [7:0] div_lim_r;
	logic       div_off_r;
	logic [1:0] gap_r;
	logic       wr_status;

	////////////////////////////////////////////////////////////////////
	// arithmetic

	always_comb begin
		sum = 9'h000;
		sum_lo = 5'h00;
		prod = 16'h0000;
		res = instr.a;
		case (instr.op)
			CSC_OP_ADD: begin
				sum = {1'b0, instr.a} + {1'b0, instr.b};
				sum_lo = {1'b0, instr.a[3:0]} + {1'b0, instr.b[3:0]};
				res = sum[7:0];
			end
			CSC_OP_SUB: begin
				// a + ~b + 1 so carry out is the inverted borrow
				sum = {1'b0, instr.a} + {1'b0, ~instr.b} + 9'h001;
				sum_lo = {1'b0, instr.a[3:0]} + {1'b0, ~instr.b[3:0]}
					+ 5'h01;
				res = sum[7:0];
			end
			CSC_OP_RR: res = {status_r[CSC_S_C], instr.a[7:1]};
			CSC_OP_RL: res = {instr.a[6:0], status_r[CSC_S_C]};
			CSC_OP_MULU: begin
				prod = instr.a * instr.b;
				res = prod[7:0];
			end
			CSC_OP_MULS: begin
				prod = 16'($signed({{8{instr.a[7]}}, instr.a})
					* $signed({{8{instr.b[7]}}, instr.b}));
				res = prod[7:0];
			end
			default: res = instr.a;
		endcase
	end

	assign wr_status = reg_wr && (reg_addr == CSC_A_STATUS);

	////////////////////////////////////////////////////////////////////
	// status register; hardware updates win over a software write

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			status_r <= CSC_RST_STATUS;
		end else begin
			status_r <= wr_status ? reg_wdata : status_r;
			case (instr.op)
				CSC_OP_FLAGZ: status_r[CSC_S_Z] <= (res == 8'h00);
				CSC_OP_ADD, CSC_OP_SUB: begin
					status_r[CSC_S_Z] <= (res == 8'h00);
					status_r[CSC_S_DC] <= sum_lo[4];
					status_r[CSC_S_C] <= sum[8];
				end
				CSC_OP_RR: status_r[CSC_S_C] <= instr.a[0];
				CSC_OP_RL: status_r[CSC_S_C] <= instr.a[7];
				CSC_OP_PAGE: status_r[7:CSC_S_PG] <= instr.b[2:0];
				CSC_OP_RET: status_r[CSC_S_SAR] <= 1'b0;
				CSC_OP_INTR: status_r[CSC_S_SSF] <= skip_r;
				default: ;
			endcase
		end
	end

	// skip state: the instruction after a skip is flushed
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			skip_r <= 1'b0;
		end else if (instr.op == CSC_OP_SKIP) begin
			skip_r <= 1'b1;
		end else if (instr.op == CSC_OP_RET) begin
			skip_r <= status_r[CSC_S_SAR];
		end else if (instr.op != CSC_OP_NONE) begin
			// interrupt return and interrupt entry also leave skipping
			skip_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prodh_r <= 8'h00;
			work_r <= 8'h00;
		end else begin
			if (instr.op == CSC_OP_MULU || instr.op == CSC_OP_MULS) begin
				prodh_r <= prod[15:8];
			end else if (reg_wr && reg_addr == CSC_A_PRODH) begin
				prodh_r <= reg_wdata;
			end
			if (instr.op inside {CSC_OP_ADD, CSC_OP_SUB, CSC_OP_RR,
				CSC_OP_RL, CSC_OP_MULU, CSC_OP_MULS}) begin
				work_r <= res;
			end else if (reg_wr && reg_addr == CSC_A_WORK) begin
				work_r <= reg_wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// speed registers

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			speed_r <= CSC_RST_SPEED;
			saved_speed_r <= CSC_RST_SPEED;
		end else begin
			// no register write path reaches speed_r
			case (instr.op)
				CSC_OP_SPEED: speed_r <= instr.b;
				CSC_OP_INTR: begin
					saved_speed_r <= speed_r;
					speed_r <= ispeed_r;
				end
				CSC_OP_RETI: speed_r <= saved_speed_r;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ispeed_r <= CSC_RST_ISPEED;
			vector_r <= CSC_RST_VEC;
		end else if (reg_wr) begin
			if (reg_addr == CSC_A_ISPEED) begin
				ispeed_r <= reg_wdata;
			end else if (reg_addr == CSC_A_VECL) begin
				vector_r[7:0] <= reg_wdata;
			end else if (reg_addr == CSC_A_VECH) begin
				vector_r[15:8] <= reg_wdata;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == CSC_A_STATUS) begin
				reg_rdata <= status_r;
			end else if (reg_addr == CSC_A_PRODH) begin
				reg_rdata <= prodh_r;
			end else if (reg_addr == CSC_A_SPEED) begin
				reg_rdata <= speed_r;
			end else if (reg_addr == CSC_A_ISPEED) begin
				reg_rdata <= ispeed_r;
			end else if (reg_addr == CSC_A_VECL) begin
				reg_rdata <= vector_r[7:0];
			end else if (reg_addr == CSC_A_VECH) begin
				reg_rdata <= vector_r[15:8];
			end else if (reg_addr == CSC_A_WORK) begin
				reg_rdata <= work_r;
			end else begin
				reg_rdata <= 8'h00;
			end
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////
	// clock source and core divider

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pll_en_r <= 1'b0;
			osc_en_r <= 1'b0;
		end else begin
			pll_en_r <= !speed_r[CSC_SP_PLL];
			osc_en_r <= !speed_r[CSC_SP_OSC];
		end
	end

	// a stopped source gives no strobes even if selected
	always_comb begin
		case (speed_r[CSC_SP_CLK+:2])
			CSC_CLK_PLL: sys_tick = pll_tick && pll_en_r;
			CSC_CLK_OSC: sys_tick = osc_tick && osc_en_r;
			CSC_CLK_RTC: sys_tick = rtc_tick;
			default: sys_tick = 1'b0;
		endcase
	end

	// new divisor is taken only at the end of a full period, so a
	// change never shortens the period in progress
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			div_cnt_r <= 8'h00;
			div_lim_r <= 8'h00;
			div_off_r <= 1'b1;
			core_tick_r <= 1'b0;
		end else begin
			core_tick_r <= 1'b0;
			if (div_off_r || (sys_tick && div_cnt_r >= div_lim_r)) begin
				div_cnt_r <= 8'h00;
				core_tick_r <= sys_tick && !div_off_r;
				div_off_r <= speed_r[CSC_SP_DIV+:4] == CSC_DIV_OFF;
				if (speed_r[CSC_SP_DIV+:4] != CSC_DIV_OFF) begin
					div_lim_r <= CSC_DIV_TAB[speed_r[CSC_SP_DIV+:4]];
				end
			end else if (sys_tick) begin
				div_cnt_r <= div_cnt_r + 8'h01;
			end
		end
	end

	// flash is slower than ram; fetches from it need spaced system clocks
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			gap_r <= CSC_FLASH_GAP;
			fetch_ok_r <= 1'b0;
		end else begin
			fetch_ok_r <= 1'b0;
			if (core_tick_r && fetch_req && fetch_ram) begin
				fetch_ok_r <= 1'b1;
			end else if (core_tick_r && fetch_req && gap_r == CSC_FLASH_GAP) begin
				fetch_ok_r <= 1'b1;
				gap_r <= 2'h0;
			end else if (sys_tick && gap_r != CSC_FLASH_GAP) begin
				gap_r <= gap_r + 2'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// interrupt and reset gathering

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_r <= 1'b0;
			core_rst_r <= 1'b1;
		end else begin
			irq_r <= (|irq_ext) || irq_periph;
			core_rst_r <= |rst_src;
		end
	end

endmodule // csc_core_state

// [shared/csc_pkg.sv]
// shared types and constants of the core state and clock select block
package csc_pkg;
	typedef enum logic [3:0] {
		CSC_OP_NONE, CSC_OP_FLAGZ, CSC_OP_ADD, CSC_OP_SUB,
		CSC_OP_RR, CSC_OP_RL, CSC_OP_MULU, CSC_OP_MULS,
		CSC_OP_PAGE, CSC_OP_RET, CSC_OP_RETI, CSC_OP_SKIP,
		CSC_OP_SPEED, CSC_OP_INTR
	} csc_op_type;

	// one retired instruction from the decoder
	typedef struct packed {
		csc_op_type op;
		logic [7:0] a;
		logic [7:0] b;
	} csc_instr_type;

	// register indices on the plain port
	localparam logic [2:0] CSC_A_STATUS = 3'h0;
	localparam logic [2:0] CSC_A_PRODH  = 3'h1;
	localparam logic [2:0] CSC_A_SPEED  = 3'h2;
	localparam logic [2:0] CSC_A_ISPEED = 3'h3;
	localparam logic [2:0] CSC_A_VECL   = 3'h4;
	localparam logic [2:0] CSC_A_VECH   = 3'h5;
	localparam logic [2:0] CSC_A_WORK   = 3'h6;

	// status fields
	localparam int CSC_S_C   = 0;
	localparam int CSC_S_DC  = 1;
	localparam int CSC_S_Z   = 2;
	localparam int CSC_S_SSF = 3;
	localparam int CSC_S_SAR = 4;
	localparam int CSC_S_PG  = 5;
	// speed fields
	localparam int CSC_SP_PLL = 7;
	localparam int CSC_SP_OSC = 6;
	localparam int CSC_SP_CLK = 4;
	localparam int CSC_SP_DIV = 0;

	localparam logic [7:0] CSC_RST_STATUS = 8'h00;
	localparam logic [7:0] CSC_RST_SPEED  = 8'h00;
	localparam logic [7:0] CSC_RST_ISPEED = 8'h00;
	localparam logic [15:0] CSC_RST_VEC   = 16'h0000;

	localparam logic [1:0] CSC_CLK_PLL = 2'h0;
	localparam logic [1:0] CSC_CLK_OSC = 2'h1;
	localparam logic [1:0] CSC_CLK_RTC = 2'h2;
	localparam logic [3:0] CSC_DIV_OFF = 4'hf;

	// core clock divisor minus one, codes 0 to 14
	localparam logic [7:0] CSC_DIV_TAB [15] = '{
		8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h09,
		8'h0b, 8'h0f, 8'h17, 8'h1f, 8'h2f, 8'h3f, 8'h7f};

	// system clocks per instruction fetched from flash, minus one
	localparam logic [1:0] CSC_FLASH_GAP = 2'h2;
	localparam int CSC_NUM_EXT_IRQ = 8;
	localparam int CSC_NUM_RST_SRC = 5;
endpackage

// [verification/csc_core_state_properties.sv]
// assertions on the ports of the core state and clock select block
`timescale 1ns/100ps
module csc_checker
	import csc_pkg::*;
(
	input wire logic                       clk,         // clock
	input wire logic                       arst_n,      // async reset
	input wire csc_instr_type              instr,       // retired instruction
	input wire logic [2:0]                 reg_addr,    // register index
	input wire logic [7:0]                 reg_wdata,   // write data
	input wire logic                       reg_wr,      // write strobe
	input wire logic                       fetch_req,   // fetch wanted
	input wire logic                       fetch_ram,   // fetch from ram
	input wire logic [CSC_NUM_EXT_IRQ-1:0] irq_ext,     // external requests
	input wire logic                       irq_periph,  // peripheral request
	input wire logic [CSC_NUM_RST_SRC-1:0] rst_src,     // reset sources
	input wire logic [7:0]                 status_r,    // flags
	input wire logic [7:0]                 prodh_r,     // product high
	input wire logic [7:0]                 work_r,      // working register
	input wire logic [7:0]                 speed_r,     // speed register
	input wire logic                       skip_r,      // skipping state
	input wire logic                       pll_en_r,    // multiplier on
	input wire logic                       osc_en_r,    // oscillator on
	input wire logic                       core_tick_r, // core clock enable
	input wire logic                       fetch_ok_r,  // fetch granted
	input wire logic                       irq_r,       // interrupt request
	input wire logic [15:0]                vector_r,    // interrupt vector
	input wire logic                       core_rst_r   // core reset
);
	logic [8:0]  sum9;
	logic [15:0] prod;
	assign sum9 = instr.a + instr.b;
	assign prod = instr.a * instr.b;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////////////////////////////////////
	property p_zero;
		instr.op == CSC_OP_FLAGZ && instr.a == 8'h00 |=> status_r[CSC_S_Z];
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag");
	property p_carry;
		instr.op == CSC_OP_ADD |=> status_r[CSC_S_C] == $past(sum9[8]);
	endproperty
	a_carry: assert property (p_carry) else $error("carry");
	property p_mul;
		instr.op == CSC_OP_MULU |=> {prodh_r, work_r} == $past(prod);
	endproperty
	a_mul: assert property (p_mul) else $error("product");
	property p_ret;
		instr.op == CSC_OP_RET && status_r[CSC_S_SAR]
			|=> skip_r && !status_r[CSC_S_SAR];
	endproperty
	a_ret: assert property (p_ret) else $error("return skip");
	property p_ssf;
		instr.op == CSC_OP_INTR |=> status_r[CSC_S_SSF] == $past(skip_r);
	endproperty
	a_ssf: assert property (p_ssf) else $error("shadow skip");
	property p_spd_ro;
		reg_wr && reg_addr == CSC_A_SPEED && instr.op == CSC_OP_NONE
			|=> $stable(speed_r);
	endproperty
	a_spd_ro: assert property (p_spd_ro) else $error("speed written");
	// enables trail the speed bits by one cycle, inverted; the edge
	// that releases reset still loads reset values, so skip it
	property p_en;
		$past(arst_n) |-> {pll_en_r, osc_en_r} == ~$past(speed_r[7:6]);
	endproperty
	a_en: assert property (p_en) else $error("enables");
	// five cycles of slack cover the tick pipeline
	property p_src_off;
		(speed_r[5:4] == 2'h3) [*5] |-> !core_tick_r;
	endproperty
	a_src_off: assert property (p_src_off) else $error("clock off");
	property p_irq;
		$past(arst_n) |-> irq_r == $past((|irq_ext) || irq_periph);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt");
	property p_rst;
		$past(arst_n) |-> core_rst_r == $past(|rst_src);
	endproperty
	a_rst: assert property (p_rst) else $error("core reset");
	property p_fram;
		core_tick_r && fetch_req && fetch_ram |=> fetch_ok_r;
	endproperty
	a_fram: assert property (p_fram) else $error("ram fetch");
	property p_fgnt;
		fetch_ok_r |-> $past(core_tick_r && fetch_req);
	endproperty
	a_fgnt: assert property (p_fgnt) else $error("fetch grant");
	property p_vec;
		reg_wr && reg_addr == CSC_A_VECL |=> vector_r[7:0] == $past(reg_wdata);
	endproperty
	a_vec: assert property (p_vec) else $error("vector low");
endmodule // csc_checker

bind csc_core_state csc_checker u_chk (.clk(clk), .arst_n(arst_n),
	.instr(instr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .fetch_req(fetch_req), .fetch_ram(fetch_ram),
	.irq_ext(irq_ext), .irq_periph(irq_periph), .rst_src(rst_src),
	.status_r(status_r), .prodh_r(prodh_r), .work_r(work_r),
	.speed_r(speed_r), .skip_r(skip_r), .pll_en_r(pll_en_r),
	.osc_en_r(osc_en_r), .core_tick_r(core_tick_r),
	.fetch_ok_r(fetch_ok_r), .irq_r(irq_r), .vector_r(vector_r),
	.core_rst_r(core_rst_r));

// [verification/tb_csc_core_state.sv]
// self-checking bench of the core state and clock select block
`timescale 1ns/100ps
module tb_csc_core_state
	import csc_pkg::*;
;
	localparam csc_op_type OPS [6] = '{CSC_OP_ADD, CSC_OP_SUB,
		CSC_OP_RR, CSC_OP_RL, CSC_OP_MULU, CSC_OP_MULS};
	logic                       clk, arst_n, reg_wr, reg_rd, pend, cb, ct;
	logic [7:0]                 gap_cnt;
	logic                       pll_tick, osc_tick, rtc_tick;
	logic                       fetch_req, fetch_ram, irq_periph;
	logic [CSC_NUM_EXT_IRQ-1:0] irq_ext;
	logic [CSC_NUM_RST_SRC-1:0] rst_src;
	logic [2:0]                 reg_addr;
	logic [7:0]                 reg_wdata, reg_rdata, st, sp, ph, w, a, b, bb;
	logic [8:0]                 r9;
	logic [15:0]                p;
	csc_instr_type              instr;
	logic [7:0]                 exp_q [$], per_q [$];
	int                         n_mismatch, compares;

	csc_core_state DUT (.clk(clk), .arst_n(arst_n), .instr(instr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .pll_tick(pll_tick),
		.osc_tick(osc_tick), .rtc_tick(rtc_tick), .fetch_req(fetch_req),
		.fetch_ram(fetch_ram), .irq_ext(irq_ext), .irq_periph(irq_periph),
		.rst_src(rst_src), .status_r(), .prodh_r(), .work_r(), .speed_r(),
		.skip_r(), .pll_en_r(), .osc_en_r(), .core_tick_r(ct), .fetch_ok_r(),
		.irq_r(), .vector_r(), .core_rst_r());

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic check(logic [7:0] seen, logic [7:0] want);
		compares++;
		if (seen !== want) begin
			n_mismatch++;
			$display("Error t=%0t seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic summarize;
		if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// an idle cycle after each access, so no strobe is set twice at one edge
	task automatic cyc(csc_op_type o, logic [7:0] x, y, logic w_en, r_en,
		logic [2:0] ad, logic [7:0] d);
		instr <= '{o, x, y};
		{reg_wr, reg_rd, reg_addr, reg_wdata} <= {w_en, r_en, ad, d};
		{pll_tick, osc_tick, rtc_tick, fetch_req, fetch_ram} <= 5'($urandom);
		{irq_ext, irq_periph} <= 9'($urandom);
		rst_src <= 5'($urandom);
		@(posedge clk);
		instr <= '{CSC_OP_NONE, 8'h00, 8'h00};
		{reg_wr, reg_rd} <= 2'b00;
		@(posedge clk);
	endtask
	task automatic ex(csc_op_type o, logic [7:0] x, y);
		cyc(o, x, y, 1'b0, 1'b0, 3'h0, 8'h00);
	endtask
	task automatic wr(logic [2:0] ad, logic [7:0] d);
		cyc(CSC_OP_NONE, 8'h00, 8'h00, 1'b1, 1'b0, ad, d);
	endtask
	task automatic rd(logic [2:0] ad, logic [7:0] e);
		exp_q.push_back(e);
		cyc(CSC_OP_NONE, 8'h00, 8'h00, 1'b0, 1'b1, ad, 8'h00);
	endtask
	// slow source strobed every cycle, so the core period in cycles is
	// the divisor; the wait covers the longest old period plus realign
	task automatic div_chk(logic [3:0] c, logic [7:0] d);
		ex(CSC_OP_SPEED, 8'h00, {4'h2, c});
		rtc_tick <= 1'b1;
		repeat (160) @(posedge clk);
		per_q.push_back(d);
		repeat (40) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	// read data stand only in the cycle after the strobe
	always @(posedge clk) pend <= reg_rd;
	always @(negedge clk) if (pend) check(reg_rdata, exp_q.pop_front());
	// cycles since the previous core clock pulse
	always @(negedge clk) begin
		if (ct && per_q.size() > 0) check(gap_cnt, per_q.pop_front());
		gap_cnt <= ct ? 8'h01 : gap_cnt + 8'h01;
	end

	initial begin
		n_mismatch = 0;
		compares = 0;
		a = 8'($urandom(37858));
		instr = '{CSC_OP_NONE, 8'h00, 8'h00};
		{reg_wr, reg_rd, reg_addr, reg_wdata} = 13'h0000;
		{pll_tick, osc_tick, rtc_tick, fetch_req, fetch_ram} = 5'h00;
		{irq_ext, irq_periph} = 9'h000;
		rst_src = 5'h00;
		arst_n = 1'b0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		st = CSC_RST_STATUS;
		ph = 8'h00;
		rd(CSC_A_STATUS, CSC_RST_STATUS);
		rd(CSC_A_SPEED, CSC_RST_SPEED);
		rd(CSC_A_ISPEED, CSC_RST_ISPEED);
		// first pass uses ff and 01 so every flag flips at the byte edge
		for (int n = 0; n < 12; n++) begin
			a = n ? 8'($urandom) : 8'hff;
			b = n ? 8'($urandom) : 8'h01;
			foreach (OPS[i]) begin
				ex(OPS[i], a, b);
				if (OPS[i] inside {CSC_OP_ADD, CSC_OP_SUB}) begin
					cb = OPS[i] == CSC_OP_SUB;
					bb = cb ? ~b : b;
					r9 = {1'b0, a} + {1'b0, bb} + {8'h00, cb};
					w = r9[7:0];
					st[CSC_S_C] = r9[8];
					st[CSC_S_Z] = w == 8'h00;
					st[CSC_S_DC] = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cb} > 5'h0f;
				end else if (OPS[i] == CSC_OP_RR) begin
					w = {st[CSC_S_C], a[7:1]};
					st[CSC_S_C] = a[0];
				end else if (OPS[i] == CSC_OP_RL) begin
					w = {a[6:0], st[CSC_S_C]};
					st[CSC_S_C] = a[7];
				end else begin
					p = a * b;
					if (OPS[i] == CSC_OP_MULS) p = $signed(a) * $signed(b);
					{ph, w} = p;
				end
				rd(CSC_A_WORK, w);
				rd(CSC_A_PRODH, ph);
				rd(CSC_A_STATUS, st);
			end
		end
		for (int k = 0; k < 2; k++) begin
			ex(CSC_OP_FLAGZ, k ? 8'h80 : 8'h00, 8'h00);
			st[CSC_S_Z] = !k;
			rd(CSC_A_STATUS, st);
		end
		for (int k = 0; k < 8; k++) begin
			ex(CSC_OP_PAGE, 8'h00, 8'(k) | 8'hf8);
			st[7:5] = 3'(k);
			rd(CSC_A_STATUS, st);
		end
		sp = 8'($urandom);
		ex(CSC_OP_SPEED, 8'h00, sp); // idle cycle follows
		rd(CSC_A_SPEED, sp);
		wr(CSC_A_SPEED, ~sp);
		rd(CSC_A_SPEED, sp);
		wr(CSC_A_ISPEED, 8'h3c);
		rd(CSC_A_ISPEED, 8'h3c);
		ex(CSC_OP_SKIP, 8'h00, 8'h00);
		ex(CSC_OP_INTR, 8'h00, 8'h00);
		st[CSC_S_SSF] = 1'b1;
		rd(CSC_A_SPEED, 8'h3c);
		rd(CSC_A_STATUS, st);
		st[CSC_S_SAR] = 1'b1;
		wr(CSC_A_STATUS, st);
		ex(CSC_OP_RETI, 8'h00, 8'h00);
		rd(CSC_A_SPEED, sp);
		rd(CSC_A_STATUS, st);
		ex(CSC_OP_RET, 8'h00, 8'h00);
		st[CSC_S_SAR] = 1'b0;
		rd(CSC_A_STATUS, st);
		wr(CSC_A_VECL, a);
		wr(CSC_A_VECH, b);
		wr(3'h7, 8'ha5);
		rd(CSC_A_VECL, a);
		rd(CSC_A_VECH, b);
		rd(3'h7, 8'h00);
		div_chk(4'h0, 8'h01);
		div_chk(4'h2, 8'h03);
		div_chk(4'h6, 8'h08);
		div_chk(4'h9, 8'h10);
		ex(CSC_OP_SPEED, 8'h00, 8'h30);
		repeat (8) @(posedge clk);
		check(8'(exp_q.size() + per_q.size()), 8'h00);
		repeat (3) @(posedge clk);
		summarize();
	end

	initial begin
		#500000;
		n_mismatch++;
		summarize();
	end
endmodule // tb_csc_core_state
